// ### rtl/tad_dio_alarm.sv
// Digital lines, temperature alarms and their settings behind an AXI4-Lite slave
`timescale 1ns/100ps
module tad_dio_alarm import tad_pkg::*; #(
	parameter int N = NCH,
	parameter int IW = $clog2(NV_WORDS)
) (
	input wire logic CLK_SYS,
	input wire logic RST,
	input wire logic [7:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [7:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic [N-1:0] DIGITAL_LINE_IN,
	output logic [N-1:0] DIGITAL_LINE_OUT,
	output logic [N-1:0] DIGITAL_LINE_OE,
	input wire logic [N*32-1:0] TEMP_DATA,
	input wire logic [N-1:0] TEMP_VALID,
	input wire logic [N-1:0] OPEN_SENSOR_DETECT,
	output logic [N*3-1:0] CH_TYPE,
	output logic [N-1:0] CH_FORMAT,
	output logic [N*32-1:0] CAL_COEF,
	output logic [IW-1:0] NV_ADDR,
	output logic NV_RD,
	output logic NV_WR,
	output logic [31:0] NV_WDATA,
	input wire logic [31:0] NV_RDATA,
	input wire logic NV_ACK,
	output logic IRQ
);
	// Order-preserving key for IEEE single: larger key means larger value
	function automatic logic [31:0] flt_key(input logic [31:0] x);
		flt_key = x[31] ? ~x : {1'b1, x[30:0]};
	endfunction : flt_key

	function automatic logic [IW-1:0] cfg_idx(input logic [7:0] a);
		logic [7:0] d;
		d = a - OFS_CFG_BASE;
		cfg_idx = d[IW+1:2];
	endfunction : cfg_idx

	function automatic logic in_cfg(input logic [7:0] a);
		in_cfg = (a >= OFS_CFG_BASE) && (a < OFS_CFG_END) && (a[1:0] == 2'b00);
	endfunction : in_cfg

	logic aw_hold_r, w_hold_r, bvalid_r, rvalid_r;
	logic [7:0] awaddr_r;
	logic [31:0] wdata_r, rdata_r;
	logic [3:0] wstrb_r;
	logic [1:0] bresp_r, rresp_r;
	logic [N-1:0] dir_r, out_r, active_r, active_nxt, assign_r, open_r, open_nxt;
	logic [N-1:0] dio_o_r, dio_oe_r, dio_o_nxt, dio_oe_nxt;
	logic [16:0] irq_stat_r, irq_en_r, irq_ev;
	logic irq_r, loaded_d_r;
	logic [31:0] cfg_r [0:NV_WORDS-1];

	logic [IW-1:0] nv_idx;
	logic ld_we, nv_loaded, nv_busy, nv_done;

	// Write channel: address and data are caught in either order
	wire aw_take = S_AXI_AWVALID & ~aw_hold_r;
	wire w_take = S_AXI_WVALID & ~w_hold_r;
	wire do_wr = aw_hold_r & w_hold_r & ~bvalid_r;
	wire [31:0] wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
	wire [31:0] wbits = wdata_r & wmask;
	wire wa_dir = (awaddr_r == OFS_DIO_DIR);
	wire wa_out = (awaddr_r == OFS_DIO_OUT);
	wire wa_ien = (awaddr_r == OFS_IRQ_EN);
	wire wa_clr = (awaddr_r == OFS_IRQ_CLR);
	wire wa_cmd = (awaddr_r == OFS_NV_CMD);
	// Settings are locked while the sequencer walks them, so a store is consistent
	wire wa_cfg = in_cfg(awaddr_r) & ~nv_busy;
	wire wa_ok = wa_dir | wa_out | wa_ien | wa_clr | wa_cmd | wa_cfg;
	wire [IW-1:0] wa_idx = cfg_idx(awaddr_r);
	wire wr_dir = do_wr & wa_dir;
	wire wr_out = do_wr & wa_out;
	wire wr_ien = do_wr & wa_ien;
	wire wr_cfg = do_wr & wa_cfg;
	wire [16:0] irq_clr = (do_wr & wa_clr) ? wbits[16:0] : 17'h0_0000;
	wire nv_commit = do_wr & wa_cmd & wbits[NV_CMD_STORE];

	// Read decode
	wire ar_take = S_AXI_ARVALID & ~rvalid_r;
	wire [7:0] ra = S_AXI_ARADDR;
	// Loaded shows only once the assignment bits have latched, so one poll sees both
	wire [31:0] st_word = {6'h00, nv_busy, loaded_d_r, open_r, assign_r, active_r};
	wire ra_cfg = in_cfg(ra);
	wire ra_ok = ra_cfg || ra == OFS_DIO_DIR || ra == OFS_DIO_OUT || ra == OFS_DIO_IN
		|| ra == OFS_ALM_STATE || ra == OFS_IRQ_STAT || ra == OFS_IRQ_EN
		|| ra == OFS_IRQ_CLR || ra == OFS_NV_CMD;
	wire [31:0] rd_mux = ra_cfg ? cfg_r[cfg_idx(ra)] :
		(ra == OFS_DIO_DIR) ? {24'h00_0000, dir_r} :
		(ra == OFS_DIO_OUT) ? {24'h00_0000, out_r} :
		(ra == OFS_DIO_IN) ? {24'h00_0000, DIGITAL_LINE_IN} :
		(ra == OFS_ALM_STATE) ? st_word :
		(ra == OFS_IRQ_STAT) ? {15'h0000, irq_stat_r} :
		(ra == OFS_IRQ_EN) ? {15'h0000, irq_en_r} :
		32'h0000_0000;

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			bvalid_r <= 1'b0;
			rvalid_r <= 1'b0;
			awaddr_r <= 8'h00;
			wdata_r <= RST_WORD;
			wstrb_r <= 4'h0;
			bresp_r <= RESP_OKAY;
			rresp_r <= RESP_OKAY;
			rdata_r <= RST_WORD;
		end else begin
			if (aw_take) begin
				aw_hold_r <= 1'b1;
				awaddr_r <= S_AXI_AWADDR;
			end else if (do_wr) begin
				aw_hold_r <= 1'b0;
			end
			if (w_take) begin
				w_hold_r <= 1'b1;
				wdata_r <= S_AXI_WDATA;
				wstrb_r <= S_AXI_WSTRB;
			end else if (do_wr) begin
				w_hold_r <= 1'b0;
			end
			if (do_wr) begin
				bvalid_r <= 1'b1;
				bresp_r <= wa_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (S_AXI_BREADY) begin
				bvalid_r <= 1'b0;
			end
			if (ar_take) begin
				rvalid_r <= 1'b1;
				rdata_r <= rd_mux;
				rresp_r <= ra_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (S_AXI_RREADY) begin
				rvalid_r <= 1'b0;
			end
		end
	end

	assign S_AXI_AWREADY = ~aw_hold_r;
	assign S_AXI_WREADY = ~w_hold_r;
	assign S_AXI_BVALID = bvalid_r;
	assign S_AXI_BRESP = bresp_r;
	assign S_AXI_ARREADY = ~rvalid_r;
	assign S_AXI_RVALID = rvalid_r;
	assign S_AXI_RDATA = rdata_r;
	assign S_AXI_RRESP = rresp_r;

	// Alarm settings, sensor types, formats and calibration share one image
	tad_nv_seq #(
		.WORDS(NV_WORDS),
		.IW(IW)
	) u_nv (
		.clk(CLK_SYS),
		.rst(RST),
		.commit(nv_commit),
		.st_data(cfg_r[nv_idx]),
		.nv_rdata(NV_RDATA),
		.nv_ack(NV_ACK),
		.idx(nv_idx),
		.nv_rd(NV_RD),
		.nv_wr(NV_WR),
		.nv_wdata(NV_WDATA),
		.ld_we(ld_we),
		.loaded(nv_loaded),
		.busy(nv_busy),
		.op_done(nv_done)
	);
	assign NV_ADDR = nv_idx;

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			for (int k = 0; k < NV_WORDS; k++)
				cfg_r[k] <= RST_WORD;
		end else if (ld_we) begin
			cfg_r[nv_idx] <= NV_RDATA;
		end else if (wr_cfg) begin
			cfg_r[wa_idx] <= (cfg_r[wa_idx] & ~wmask) | wbits;
		end
	end

	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_ch
			assign CH_TYPE[g*3 +: 3] = cfg_r[NV_CH_CFG + g][2:0];
			assign CH_FORMAT[g] = cfg_r[NV_CH_CFG + g][CCFG_FMT];
			assign CAL_COEF[g*32 +: 32] = cfg_r[NV_CAL + g];
		end
	endgenerate

	// No mode input gates evaluation: logging and host use behave the same
	always_comb begin
		active_nxt = active_r;
		open_nxt = open_r;
		for (int c = 0; c < N; c++) begin
			if (TEMP_VALID[c])
				open_nxt[c] = OPEN_SENSOR_DETECT[c];
		end
		for (int a = 0; a < N; a++) begin
			logic [31:0] ctl;
			logic [2:0] sel;
			logic [31:0] smp;
			logic hi;
			ctl = cfg_r[NV_ALM_CTRL + a];
			sel = ctl[ACTL_SEL_LSB +: 3];
			smp = TEMP_DATA[sel*32 +: 32];
			hi = flt_key(smp) > flt_key(cfg_r[NV_ALM_THR + a]);
			// Open sensor gives no reading, so the alarm keeps its last state
			if (TEMP_VALID[sel] && !OPEN_SENSOR_DETECT[sel])
				active_nxt[a] = ctl[ACTL_BELOW] ? (flt_key(smp) < flt_key(cfg_r[NV_ALM_THR + a])) : hi;
			if (!assign_r[a])
				active_nxt[a] = 1'b0;
		end
	end

	always_comb begin
		for (int a = 0; a < N; a++) begin
			if (assign_r[a]) begin
				dio_oe_nxt[a] = 1'b1;
				dio_o_nxt[a] = active_nxt[a] ? cfg_r[NV_ALM_CTRL + a][ACTL_POL]
					: ~cfg_r[NV_ALM_CTRL + a][ACTL_POL];
			end else begin
				dio_oe_nxt[a] = dir_r[a];
				dio_o_nxt[a] = out_r[a];
			end
		end
	end

	assign irq_ev = {nv_done, active_nxt & ~active_r, open_nxt & ~open_r};

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			dir_r <= RST_DIO_DIR;
			out_r <= RST_DIO_OUT;
			active_r <= '0;
			open_r <= '0;
			assign_r <= '0;
			loaded_d_r <= 1'b0;
			dio_o_r <= '0;
			dio_oe_r <= '0;
			irq_stat_r <= '0;
			irq_en_r <= '0;
			irq_r <= 1'b0;
		end else begin
			if (wr_dir)
				dir_r <= (dir_r & ~wmask[7:0]) | wbits[7:0];
			if (wr_out)
				out_r <= (out_r & ~wmask[7:0]) | wbits[7:0];
			if (wr_ien)
				irq_en_r <= (irq_en_r & ~wmask[16:0]) | wbits[16:0];
			active_r <= active_nxt;
			open_r <= open_nxt;
			loaded_d_r <= nv_loaded;
			// Assignment is sampled once after restore, so a change waits for power-up
			if (nv_loaded & ~loaded_d_r) begin
				for (int a = 0; a < N; a++)
					assign_r[a] <= cfg_r[NV_ALM_CTRL + a][ACTL_ASSIGN];
			end
			dio_o_r <= dio_o_nxt;
			dio_oe_r <= dio_oe_nxt;
			// A new event in the clearing cycle stays set
			irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_ev;
			irq_r <= |(((irq_stat_r & ~irq_clr) | irq_ev) & irq_en_r);
		end
	end

	assign DIGITAL_LINE_OUT = dio_o_r;
	assign DIGITAL_LINE_OE = dio_oe_r;
	assign IRQ = irq_r;
endmodule : tad_dio_alarm

// ### inc/tad_pkg.sv
// Shared constants and types for the temperature alarm digital I/O block
package tad_pkg;
	localparam int NCH = 8;
	localparam int NV_WORDS = 32;
	localparam logic [7:0] OFS_DIO_DIR = 8'h00;
	localparam logic [7:0] OFS_DIO_OUT = 8'h04;
	localparam logic [7:0] OFS_DIO_IN = 8'h08;
	localparam logic [7:0] OFS_ALM_STATE = 8'h0c;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
	localparam logic [7:0] OFS_IRQ_EN = 8'h14;
	localparam logic [7:0] OFS_IRQ_CLR = 8'h18;
	localparam logic [7:0] OFS_NV_CMD = 8'h1c;
	localparam logic [7:0] OFS_CFG_BASE = 8'h40;
	localparam logic [7:0] OFS_CFG_END = 8'hc0;
	localparam int NV_ALM_CTRL = 0;
	localparam int NV_ALM_THR = 8;
	localparam int NV_CH_CFG = 16;
	localparam int NV_CAL = 24;
	localparam int ACTL_ASSIGN = 0;
	localparam int ACTL_SEL_LSB = 1;
	localparam int ACTL_POL = 4;
	localparam int ACTL_BELOW = 5;
	localparam int CCFG_FMT = 3;
	localparam int ST_ACTIVE_LSB = 0;
	localparam int ST_ASSIGN_LSB = 8;
	localparam int ST_OPEN_LSB = 16;
	localparam int ST_LOADED = 24;
	localparam int ST_BUSY = 25;
	localparam int IRQ_OPEN_LSB = 0;
	localparam int IRQ_ALM_LSB = 8;
	localparam int IRQ_NV = 16;
	localparam int NV_CMD_STORE = 0;
	localparam logic [7:0] RST_DIO_DIR = 8'h00;
	localparam logic [7:0] RST_DIO_OUT = 8'h00;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [2:0] {
		NV_LOAD = 3'b000,
		NV_LWAIT = 3'b001,
		NV_IDLE = 3'b010,
		NV_STORE = 3'b011,
		NV_SWAIT = 3'b100
	} tad_nv_state_t;
endpackage : tad_pkg

// ### rtl/tad_nv_seq.sv
// Non-volatile settings sequencer: restore at power-up, store on command
`timescale 1ns/100ps
module tad_nv_seq import tad_pkg::*; #(
	parameter int WORDS = NV_WORDS,
	parameter int IW = $clog2(NV_WORDS)
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic commit,
	input wire logic [31:0] st_data,
	input wire logic [31:0] nv_rdata,
	input wire logic nv_ack,
	output logic [IW-1:0] idx,
	output logic nv_rd,
	output logic nv_wr,
	output logic [31:0] nv_wdata,
	output logic ld_we,
	output logic loaded,
	output logic busy,
	output logic op_done
);
	tad_nv_state_t state_r, state_nxt;
	logic [IW-1:0] idx_r, idx_nxt;
	logic rd_r, wr_r, loaded_r;
	logic [31:0] wdata_r;
	wire last = (idx_r == IW'(WORDS - 1));
	wire lwait_ack = (state_r == NV_LWAIT) & nv_ack;
	wire swait_ack = (state_r == NV_SWAIT) & nv_ack;

	// Request is held as a level until the memory acknowledges it
	always_comb begin
		state_nxt = state_r;
		idx_nxt = idx_r;
		case (state_r)
			NV_LOAD: state_nxt = NV_LWAIT;
			NV_LWAIT: if (nv_ack) begin
				state_nxt = last ? NV_IDLE : NV_LOAD;
				idx_nxt = last ? '0 : idx_r + 1'b1;
			end
			NV_IDLE: if (commit) begin
				state_nxt = NV_STORE;
				idx_nxt = '0;
			end
			NV_STORE: state_nxt = NV_SWAIT;
			NV_SWAIT: if (nv_ack) begin
				state_nxt = last ? NV_IDLE : NV_STORE;
				idx_nxt = last ? '0 : idx_r + 1'b1;
			end
			default: state_nxt = NV_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_r <= NV_LOAD;
			idx_r <= '0;
			rd_r <= 1'b0;
			wr_r <= 1'b0;
			wdata_r <= RST_WORD;
			loaded_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			idx_r <= idx_nxt;
			rd_r <= (state_nxt == NV_LWAIT);
			wr_r <= (state_nxt == NV_SWAIT);
			if (state_r == NV_STORE)
				wdata_r <= st_data;
			if (lwait_ack & last)
				loaded_r <= 1'b1;
		end
	end

	assign idx = idx_r;
	assign nv_rd = rd_r;
	assign nv_wr = wr_r;
	assign nv_wdata = wdata_r;
	assign ld_we = lwait_ack;
	assign loaded = loaded_r;
	assign busy = (state_r != NV_IDLE);
	assign op_done = (lwait_ack | swait_ack) & last;
endmodule : tad_nv_seq

// ### bench/tad_pin_model.sv
// Terminal-side model: external drivers and the line pull-up
`timescale 1ns/100ps
module tad_pin_model (
	input wire logic [7:0] oe,
	input wire logic [7:0] drv,
	input wire logic [7:0] ext_en,
	input wire logic [7:0] ext_val,
	output logic [7:0] lvl
);
	// Released lines rest high through the pull-up, never at a stale value
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			lvl[i] = oe[i] ? drv[i] : (ext_en[i] ? ext_val[i] : 1'b1);
		end
	end
endmodule : tad_pin_model

// ### bench/tad_dio_alarm_sva.sv
// Port-level checks for the digital line and alarm block
`timescale 1ns/100ps
module tad_dio_alarm_sva import tad_pkg::*; #(
	parameter int N = NCH,
	parameter int IW = $clog2(NV_WORDS)
) (
	input wire logic CLK_SYS,
	input wire logic RST,
	input wire logic S_AXI_AWVALID,
	input wire logic S_AXI_AWREADY,
	input wire logic S_AXI_WVALID,
	input wire logic S_AXI_WREADY,
	input wire logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic S_AXI_ARVALID,
	input wire logic S_AXI_ARREADY,
	input wire logic S_AXI_RVALID,
	input wire logic [N-1:0] DIGITAL_LINE_OUT,
	input wire logic [N-1:0] DIGITAL_LINE_OE,
	input wire logic IRQ,
	input wire logic [IW-1:0] NV_ADDR,
	input wire logic NV_RD,
	input wire logic NV_WR,
	input wire logic NV_ACK
);
	logic [IW-1:0] ack_addr_r;
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (RST);
	always_ff @(posedge CLK_SYS) begin
		if (NV_ACK) begin
			ack_addr_r <= NV_ADDR;
		end
	end
	// Reset must release every pin so nothing is driven before settings load
	property p_oe_rst;
		disable iff (1'b0) RST |=> DIGITAL_LINE_OE == '0 && DIGITAL_LINE_OUT == '0 && !IRQ;
	endproperty
	a_oe_rst: assert property (p_oe_rst) else $error("pins not released in reset");
	property p_nv_first;
		$fell(RST) |-> ##[0:3] (NV_RD && NV_ADDR == '0);
	endproperty
	a_nv_first: assert property (p_nv_first) else $error("settings restore did not start");
	property p_nv_seq;
		$rose(NV_RD) |-> NV_ADDR == '0 || NV_ADDR == ack_addr_r + 1;
	endproperty
	a_nv_seq: assert property (p_nv_seq) else $error("restore word order broken");
	property p_nv_hold;
		NV_RD && !NV_ACK |=> NV_RD && $stable(NV_ADDR);
	endproperty
	a_nv_hold: assert property (p_nv_hold) else $error("storage request dropped");
	property p_nv_excl;
		!(NV_RD && NV_WR);
	endproperty
	a_nv_excl: assert property (p_nv_excl) else $error("storage read and write together");
	property p_wr_resp;
		S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##[1:2] S_AXI_BVALID;
	endproperty
	a_wr_resp: assert property (p_wr_resp) else $error("write response late");
	property p_b_done;
		S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID;
	endproperty
	a_b_done: assert property (p_b_done) else $error("write response not retired");
	property p_rd_lat;
		S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID;
	endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read data late");
	c_irq: cover property ($rose(IRQ));
	c_store: cover property ($rose(NV_WR));
	c_alarm: cover property ($rose(DIGITAL_LINE_OUT[0]));
endmodule : tad_dio_alarm_sva
bind tad_dio_alarm tad_dio_alarm_sva #(.N(N), .IW(IW)) u_sva (.*);

// ### bench/tad_dio_alarm_tb.sv
// Self-checking bench for the digital line and alarm block
`timescale 1ns/100ps
module tad_dio_alarm_tb import tad_pkg::*; ;
	logic clk, rst, awv, wv, bry, arv, rry, nv_ack, irq, awr, wr, bv, arr, rv, nrd, nwr;
	logic [7:0] awa, ara, ext_en, ext_val, lvl, dout, doe, tv, od, fmt;
	logic [31:0] wd, rd, nv_rdata, nv_wdata, d;
	logic [1:0] br, rr, r;
	logic [255:0] temp, cal;
	logic [23:0] ctype;
	logic [4:0] nv_addr;
	logic [31:0] mem [32];
	int error_cnt = 0, checked = 0, cyc = 0;
	tad_dio_alarm dut (.CLK_SYS(clk), .RST(rst), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
		.S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr), .S_AXI_BRESP(br),
		.S_AXI_BVALID(bv), .S_AXI_BREADY(bry), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
		.S_AXI_RDATA(rd), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rry), .DIGITAL_LINE_IN(lvl),
		.DIGITAL_LINE_OUT(dout), .DIGITAL_LINE_OE(doe), .TEMP_DATA(temp), .TEMP_VALID(tv),
		.OPEN_SENSOR_DETECT(od), .CH_TYPE(ctype), .CH_FORMAT(fmt), .CAL_COEF(cal), .NV_ADDR(nv_addr),
		.NV_RD(nrd), .NV_WR(nwr), .NV_WDATA(nv_wdata), .NV_RDATA(nv_rdata), .NV_ACK(nv_ack), .IRQ(irq));
	tad_pin_model pins (.oe(doe), .drv(dout), .ext_en(ext_en), .ext_val(ext_val), .lvl(lvl));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// Storage answers one cycle late; idle read data toggles so a stale word is never trusted
	always @(posedge clk) begin
		nv_ack <= (nrd | nwr) & ~nv_ack;
		nv_rdata <= nrd ? mem[nv_addr] : ~nv_rdata;
		if (nwr & ~nv_ack) begin
			mem[nv_addr] <= nv_wdata;
		end
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			give_verdict();
		end
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
		logic ha, hw;
		@(posedge clk);
		awa <= a;
		wd <= v;
		awv <= 1'b1;
		wv <= 1'b1;
		bry <= 1'b1;
		do begin
			@(negedge clk);
			ha = awv & awr;
			hw = wv & wr;
			@(posedge clk);
			if (ha) awv <= 1'b0;
			if (hw) wv <= 1'b0;
		end while ((awv & ~ha) | (wv & ~hw));
		do @(negedge clk); while (!bv);
		r = br;
		@(posedge clk);
		bry <= 1'b0;
	endtask : axi_wr
	task automatic axi_rd(input logic [7:0] a);
		logic h;
		@(posedge clk);
		ara <= a;
		arv <= 1'b1;
		rry <= 1'b1;
		do begin
			@(negedge clk);
			h = arr;
			@(posedge clk);
		end while (!h);
		arv <= 1'b0;
		do @(negedge clk); while (!rv);
		d = rd;
		r = rr;
		@(posedge clk);
		rry <= 1'b0;
	endtask : axi_rd
	task automatic strobe(input int c, input logic [31:0] v, input logic o);
		@(posedge clk);
		temp[c*32+:32] <= v;
		tv[c] <= 1'b1;
		od[c] <= o;
		@(posedge clk);
		tv <= 8'h00;
		od <= 8'h00;
		repeat (3) @(negedge clk);
	endtask : strobe
	// Busy rises with the write response of the store command; the caller also lets a few cycles pass first
	task automatic wait_nv();
		do axi_rd(OFS_ALM_STATE); while (!d[ST_LOADED] || d[ST_BUSY]);
	endtask : wait_nv
	task automatic t_load();
		wait_nv();
		chk("assigned", 32'h3, {24'h0, d[15:8]});
		chk("oe", 32'h3, {24'h0, doe & 8'h03});
		chk("idle_level", 32'h2, {24'h0, dout & 8'h03});
		chk("type", 32'h5, {29'h0, ctype[2:0]});
		chk("format", 32'h1, {31'h0, fmt[0]});
		chk("cal", 32'h3f80_0000, cal[31:0]);
		$display("test load done");
	endtask : t_load
	task automatic t_alarm();
		axi_wr(OFS_IRQ_EN, 32'h0);
		strobe(0, 32'h4316_0000, 1'b0);
		chk("chan_sel", 32'h0, {31'h0, dout[0]});
		strobe(2, 32'h4316_0000, 1'b0);
		chk("act_high", 32'h1, {31'h0, dout[0]});
		chk("irq_masked", 32'h0, {31'h0, irq});
		strobe(3, 32'h40a0_0000, 1'b0);
		chk("act_low", 32'h0, {31'h0, dout[1]});
		strobe(2, 32'h4248_0000, 1'b1);
		chk("open_hold", 32'h1, {31'h0, dout[0]});
		axi_rd(OFS_ALM_STATE);
		chk("open_flag", 32'h4, {24'h0, d[23:16]});
		strobe(2, 32'h4248_0000, 1'b0);
		chk("inactive", 32'h0, {31'h0, dout[0]});
		axi_wr(OFS_IRQ_EN, 32'h100);
		repeat (2) @(negedge clk);
		chk("irq_on", 32'h1, {31'h0, irq});
		axi_wr(OFS_IRQ_CLR, 32'h1_ffff);
		repeat (2) @(negedge clk);
		chk("irq_clr", 32'h0, {31'h0, irq});
		$display("test alarm done");
	endtask : t_alarm
	task automatic t_dio();
		axi_wr(OFS_DIO_DIR, 32'hf1);
		axi_wr(OFS_DIO_OUT, 32'ha0);
		ext_en <= 8'h04;
		ext_val <= 8'h00;
		repeat (3) @(negedge clk);
		chk("oe_dir", 32'hf3, {24'h0, doe});
		axi_rd(OFS_DIO_IN);
		chk("pin_in", 32'ha8, {24'h0, d[7:2], 2'b00});
		$display("test dio done");
	endtask : t_dio
	task automatic t_bus();
		axi_rd(8'h30);
		chk("rd_unmapped", {30'h0, RESP_SLVERR}, {30'h0, r});
		axi_wr(8'h30, 32'h1);
		chk("wr_unmapped", {30'h0, RESP_SLVERR}, {30'h0, r});
		axi_wr(OFS_CFG_BASE + 8'h08, 32'h1);
		axi_wr(OFS_NV_CMD, 32'h1);
		repeat (2) @(posedge clk);
		ext_en <= 8'h00;
		wait_nv();
		chk("stored", 32'h1, mem[2]);
		chk("not_yet", 32'h3, {24'h0, d[15:8]});
		rst <= 1'b1;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		wait_nv();
		chk("reassigned", 32'h7, {24'h0, d[15:8]});
		chk("oe_alarm", 32'h7, {24'h0, doe});
		$display("test bus done");
	endtask : t_bus
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : give_verdict
	initial begin
		{rst, awv, wv, bry, arv, rry} = 6'h20;
		{awa, ara, ext_en, ext_val, tv, od} = 48'h0;
		{wd, temp} = 288'h0;
		for (int i = 0; i < 32; i++) mem[i] = 32'h0;
		mem[0] = 32'h15;
		mem[1] = 32'h27;
		mem[8] = 32'h42c8_0000;
		mem[9] = 32'h4120_0000;
		mem[16] = 32'hd;
		mem[24] = 32'h3f80_0000;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		t_load();
		t_alarm();
		t_dio();
		t_bus();
		give_verdict();
	end
endmodule : tad_dio_alarm_tb
